// ---- dv/cbu_mem_model.sv ----
// Program memory model answering the branch unit's bus reads
`timescale 1ns/10ps
module cbu_mem_model (
  // Clock and bus
  input wire logic clk_in,
  input wire logic [15:0] addr_in,
  input wire logic valid_in,
  // Contents
  input wire logic [15:0] base_in,
  input wire logic [7:0] op_in,
  input wire logic [7:0] ofs_in,
  // Read data
  output logic [7:0] data_out
);
  logic flip = 1'b0;
  always_ff @(posedge clk_in) begin
    flip <= ~flip;
  end
  // Idle or off-target reads see a pattern that changes every cycle
  always_comb begin
    if (valid_in && addr_in === base_in) begin
      data_out = op_in;
    end else if (valid_in && addr_in === base_in + 16'h0001) begin
      data_out = ofs_in;
    end else begin
      data_out = flip ? 8'hA5 : 8'h5A;
    end
  end
endmodule

// ---- dv/conditional_branch_unit_tb_top.sv ----
// Self-checking bench for the branch sequencer
`timescale 1ns/10ps
module conditional_branch_unit_tb_top;
  logic clk_in, nrst_in, start_in, rw, valid, busy, done, taken, illegal;
  logic [15:0] pc_in, addr, pc_new, base;
  logic [7:0] flags_in, data, flags_new, op, ofs;
  int mismatches = 0;
  int total_checks = 0;
  // Opcode, flag nibble N Z V C, expected taken
  logic [15:0] rows [32] = '{16'h2001, 16'h21F0, 16'h2201, 16'h2210, 16'h2341, 16'h2300,
    16'h2401, 16'h2410, 16'h2511, 16'h2500, 16'h2601, 16'h2640, 16'h2741, 16'h2700,
    16'h2801, 16'h2820, 16'h2921, 16'h2900, 16'h2A01, 16'h2A80, 16'h2B81, 16'h2B00,
    16'h2CA1, 16'h2C80, 16'h2D21, 16'h2DA0, 16'h2E01, 16'h2E40, 16'h2E80, 16'h2F41,
    16'h2F00, 16'h2F81};
  cbu_branch_unit i_cbu_branch_unit (.clk_in(clk_in), .nrst_in(nrst_in), .start_in(start_in),
    .pc_in(pc_in), .flags_in(flags_in), .addr_out(addr), .rw_out(rw), .bus_valid_out(valid),
    .data_in(data), .busy_out(busy), .done_out(done), .taken_out(taken),
    .illegal_out(illegal), .pc_out(pc_new), .flags_out(flags_new));
  cbu_mem_model i_cbu_mem_model (.clk_in(clk_in), .addr_in(addr), .valid_in(valid),
    .base_in(base), .op_in(op), .ofs_in(ofs), .data_out(data));
  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: %s got %h expected %h", $time, msg, seen, exp);
    end
  endtask
  task automatic close_out;
    if (mismatches == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic run(input logic [15:0] p, input logic [7:0] o, input logic [7:0] f,
      input logic [7:0] r, input logic t, input logic ill);
    logic [15:0] nxt;
    nxt = p + 16'h0002 + (t ? {{8{r[7]}}, r} : 16'h0000);
    base = p;
    op = o;
    ofs = r;
    pc_in = p;
    flags_in = f;
    start_in = 1'b1;
    @(posedge clk_in);
    #1 start_in = 1'b0;
    chk(addr, p, "opcode fetch");
    chk({13'h0, busy, valid, rw}, 16'h0007, "read cycle");
    @(posedge clk_in);
    #1 chk(addr, p + 16'h0001, "offset fetch");
    @(posedge clk_in);
    #1 chk(addr, 16'hFFFF, "dummy read");
    chk({15'h0, done}, 16'h0000, "early done");
    @(posedge clk_in);
    #1 chk({13'h0, done, valid, busy}, 16'h0004, "done");
    chk({15'h0, taken}, {15'h0, t}, "taken");
    chk(pc_new, nxt, "new pc");
    chk({8'h00, flags_new}, {8'h00, f}, "flags");
    chk({15'h0, illegal}, {15'h0, ill}, "illegal");
  endtask
  initial begin
    nrst_in = 1'b0;
    start_in = 1'b0;
    pc_in = 16'h0000;
    flags_in = 8'h00;
    base = 16'h0000;
    op = 8'h00;
    ofs = 8'h00;
    repeat (3) @(posedge clk_in);
    #1 chk(pc_new, 16'h0000, "reset pc");
    chk({14'h0, busy, done}, 16'h0000, "reset status");
    chk(addr, 16'h0000, "idle address");
    nrst_in = 1'b1;
    for (int i = 0; i < 32; i++) begin
      run(16'h1000 + 16'(i * 16), rows[i][15:8], {4'hA, rows[i][7:4]},
        i[0] ? 8'h7F : 8'h80, rows[i][0], 1'b0);
    end
    // Address wrap and a non-branch opcode
    run(16'hFFFE, 8'h20, 8'h00, 8'h01, 1'b1, 1'b0);
    run(16'h2000, 8'h12, 8'hFF, 8'hF0, 1'b0, 1'b1);
    // Reset in mid-branch
    pc_in = 16'h3000;
    start_in = 1'b1;
    @(posedge clk_in);
    #1 start_in = 1'b0;
    nrst_in = 1'b0;
    #1 chk({14'h0, busy, done}, 16'h0000, "abort status");
    chk(pc_new, 16'h0000, "abort pc");
    @(posedge clk_in);
    #1 nrst_in = 1'b1;
    @(posedge clk_in);
    #1 run(16'h0100, 8'h27, 8'h04, 8'hFE, 1'b1, 1'b0);
    close_out;
  end
  initial begin
    #200000;
    mismatches++;
    close_out;
  end
endmodule

// ---- src/cbu_branch_unit.sv ----
// Sequencer executing relative conditional branches on the memory bus
// Summary of operation
// - Opcode 25 branches only when carry is one.
// - Opcode 27 branches on zero set, opcode 26 on zero clear.
// - Opcode 2C branches when negative XOR overflow is zero.
// - Opcode 2E branches when zero OR (negative XOR overflow) is zero.
// - Opcode 2F branches when zero OR (N XOR V) is one, 2D when N XOR V is one.
// - Opcode 22 on C OR Z zero, 23 on C OR Z one, 24 on carry zero.
// - Opcode 2B branches on negative set, 2A on negative clear.
// - Opcode 29 branches on overflow set, 28 on overflow clear.
// - A taken branch loads opcode address plus 0002 plus the offset.
// - Each branch is three read cycles: opcode, offset, dummy read at FFFF.
// - No branch alters any of the eight condition flag bits.
// - Signed conditions use flags as left by a preceding compare or subtract.
`timescale 1ns/10ps
`include "cbu_map.svh"
module cbu_branch_unit #(
  parameter logic [15:0] PC_RESET = `CBU_PC_RESET
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // Start request
  input wire logic start_in,
  input wire logic [15:0] pc_in,
  input wire logic [7:0] flags_in,
  // Memory bus
  output logic [15:0] addr_out,
  output logic rw_out,
  output logic bus_valid_out,
  input wire logic [7:0] data_in,
  // Result
  output logic busy_out,
  output logic done_out,
  output logic taken_out,
  output logic illegal_out,
  output logic [15:0] pc_out,
  output logic [7:0] flags_out
);
  cbu_pkg::cbu_state_t state;
  cbu_pkg::cbu_state_t next_state;
  logic [15:0] op_addr;
  logic [7:0] opcode;
  logic [7:0] flags;
  logic is_branch;
  logic take;

  function automatic logic [15:0] rel_target(input logic [15:0] base, input logic [7:0] ofs);
    rel_target = base + `CBU_PC_STEP + {{8{ofs[7]}}, ofs};
  endfunction

  cbu_cond_eval u_eval (
    .opcode_in(opcode),
    .flags_in(flags),
    .is_branch_out(is_branch),
    .take_out(take)
  );

  // Sequence of three read cycles
  always_comb begin
    case (state)
      cbu_pkg::CBU_IDLE: next_state = start_in ? cbu_pkg::CBU_FETCH_OP : cbu_pkg::CBU_IDLE;
      cbu_pkg::CBU_FETCH_OP: next_state = cbu_pkg::CBU_FETCH_OFS;
      cbu_pkg::CBU_FETCH_OFS: next_state = cbu_pkg::CBU_DUMMY;
      cbu_pkg::CBU_DUMMY: next_state = cbu_pkg::CBU_IDLE;
      default: next_state = cbu_pkg::CBU_IDLE;
    endcase
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state <= cbu_pkg::CBU_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Bus drive: all reads
  always_comb begin
    case (state)
      cbu_pkg::CBU_FETCH_OP: addr_out = op_addr;
      cbu_pkg::CBU_FETCH_OFS: addr_out = op_addr + 16'h0001;
      cbu_pkg::CBU_DUMMY: addr_out = `CBU_DUMMY_ADDR;
      default: addr_out = 16'h0000;
    endcase
  end
  assign rw_out = 1'b1;
  assign bus_valid_out = (state != cbu_pkg::CBU_IDLE);
  assign busy_out = bus_valid_out;

  // Captured request
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      op_addr <= 16'h0000;
      flags <= 8'h00;
    end else if (state == cbu_pkg::CBU_IDLE && start_in) begin
      op_addr <= pc_in;
      flags <= flags_in;
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      opcode <= 8'h00;
    end else if (state == cbu_pkg::CBU_FETCH_OP) begin
      opcode <= data_in;
    end
  end

  // Results, updated at the end of the offset read and flagged by done_out after the dummy cycle
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pc_out <= PC_RESET;
      taken_out <= 1'b0;
      illegal_out <= 1'b0;
      flags_out <= 8'h00;
    end else if (state == cbu_pkg::CBU_FETCH_OFS) begin
      taken_out <= is_branch & take;
      illegal_out <= ~is_branch;
      flags_out <= flags;
      if (is_branch && take) begin
        pc_out <= rel_target(op_addr, data_in);
      end else begin
        pc_out <= op_addr + `CBU_PC_STEP;
      end
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      done_out <= 1'b0;
    end else begin
      done_out <= (state == cbu_pkg::CBU_DUMMY);
    end
  end

  sequence s_three_reads;
    (addr_out == op_addr && rw_out) ##1 (addr_out == op_addr + 16'h0001 && rw_out)
      ##1 (addr_out == `CBU_DUMMY_ADDR && rw_out);
  endsequence

  a_bus_sequence: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (state == cbu_pkg::CBU_IDLE && start_in) |=> s_three_reads ##1 done_out)
    else $error("branch bus sequence wrong");

  a_flags_kept: assert property (@(posedge clk_in) disable iff (!nrst_in)
    done_out |-> flags_out == $past(flags_in, 4))
    else $error("flags changed by branch");

  a_not_taken_pc: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (done_out && !taken_out) |-> pc_out == op_addr + 16'h0002)
    else $error("untaken pc wrong");

  a_taken_pc: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (state == cbu_pkg::CBU_FETCH_OFS && is_branch && take)
      |=> pc_out == op_addr + 16'h0002 + {{8{$past(data_in[7])}}, $past(data_in)})
    else $error("taken pc wrong");

  a_carry_set: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (done_out && opcode == 8'h25) |-> taken_out == flags[0])
    else $error("carry set branch wrong");

  a_zero_pair: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (done_out && (opcode == 8'h26 || opcode == 8'h27)) |-> taken_out == (flags[2] == opcode[0]))
    else $error("equal branch wrong");

  a_signed_ge: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (done_out && opcode == 8'h2C) |-> taken_out == !(flags[3] ^ flags[1]))
    else $error("signed ge wrong");

  a_signed_gt: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (done_out && opcode == 8'h2E) |-> taken_out == !(flags[2] | (flags[3] ^ flags[1])))
    else $error("signed gt wrong");

  a_always_never: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (done_out && opcode[7:1] == 7'h10) |-> taken_out == !opcode[0])
    else $error("always or never wrong");

  a_unsigned_gt: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (done_out && opcode == `CBU_OP_UGT) |-> taken_out == !(flags[0] | flags[2]))
    else $error("unsigned gt wrong");

  a_unsigned_le: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (done_out && opcode == `CBU_OP_ULE) |-> taken_out == (flags[0] | flags[2]))
    else $error("unsigned le wrong");

  a_carry_clear: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (done_out && opcode == `CBU_OP_CARRY_CLEAR) |-> taken_out == !flags[0])
    else $error("carry clear branch wrong");

  a_signed_lt: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (done_out && opcode == `CBU_OP_SLT) |-> taken_out == (flags[3] ^ flags[1]))
    else $error("signed lt wrong");

  a_signed_le: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (done_out && opcode == `CBU_OP_SLE) |-> taken_out == (flags[2] | (flags[3] ^ flags[1])))
    else $error("signed le wrong");

  a_negative_pair: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (done_out && (opcode == `CBU_OP_POSITIVE || opcode == `CBU_OP_NEGATIVE)) |->
      taken_out == (flags[3] == opcode[0]))
    else $error("negative branch wrong");

  a_overflow_pair: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (done_out && (opcode == `CBU_OP_OVF_CLEAR || opcode == `CBU_OP_OVF_SET)) |->
      taken_out == (flags[1] == opcode[0]))
    else $error("overflow branch wrong");

  a_done_pulse: assert property (@(posedge clk_in) disable iff (!nrst_in)
    done_out |=> !done_out)
    else $error("done longer than one cycle");

  a_untaken_illegal: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (done_out && illegal_out) |-> (!taken_out && pc_out == op_addr + `CBU_PC_STEP))
    else $error("non-branch opcode handled wrong");

  a_flags_held: assert property (@(posedge clk_in) disable iff (!nrst_in)
    bus_valid_out |=> $stable(flags))
    else $error("captured flags moved during branch");
endmodule

// ---- src/cbu_cond_eval.sv ----
// Branch condition evaluator for the relative branch family
`timescale 1ns/10ps
`include "cbu_map.svh"
module cbu_cond_eval (
  // Operation
  input wire logic [7:0] opcode_in,
  input wire logic [7:0] flags_in,
  // Result
  output logic is_branch_out,
  output logic take_out
);
  logic c;
  logic v;
  logic z;
  logic n;
  assign c = flags_in[`CBU_FLAG_C];
  assign v = flags_in[`CBU_FLAG_V];
  assign z = flags_in[`CBU_FLAG_Z];
  assign n = flags_in[`CBU_FLAG_N];
  assign is_branch_out = (opcode_in[7:4] == 4'h2);
  always_comb begin
    case (opcode_in)
      `CBU_OP_ALWAYS: take_out = 1'b1;
      `CBU_OP_NEVER: take_out = 1'b0;
      `CBU_OP_UGT: take_out = ~(c | z);
      `CBU_OP_ULE: take_out = c | z;
      `CBU_OP_CARRY_CLEAR: take_out = ~c;
      `CBU_OP_CARRY_SET: take_out = c;
      `CBU_OP_NOT_EQUAL: take_out = ~z;
      `CBU_OP_EQUAL: take_out = z;
      `CBU_OP_OVF_CLEAR: take_out = ~v;
      `CBU_OP_OVF_SET: take_out = v;
      `CBU_OP_POSITIVE: take_out = ~n;
      `CBU_OP_NEGATIVE: take_out = n;
      `CBU_OP_SGE: take_out = ~(n ^ v);
      `CBU_OP_SLT: take_out = n ^ v;
      `CBU_OP_SGT: take_out = ~(z | (n ^ v));
      `CBU_OP_SLE: take_out = z | (n ^ v);
      default: take_out = 1'b0;
    endcase
  end
endmodule

// ---- src/cbu_map.svh ----
// Opcodes, flag positions, bus addresses and reset values of the branch unit
`ifndef CBU_MAP_SVH
`define CBU_MAP_SVH
`define CBU_OP_ALWAYS 8'h20
`define CBU_OP_NEVER 8'h21
`define CBU_OP_UGT 8'h22
`define CBU_OP_ULE 8'h23
`define CBU_OP_CARRY_CLEAR 8'h24
`define CBU_OP_CARRY_SET 8'h25
`define CBU_OP_NOT_EQUAL 8'h26
`define CBU_OP_EQUAL 8'h27
`define CBU_OP_OVF_CLEAR 8'h28
`define CBU_OP_OVF_SET 8'h29
`define CBU_OP_POSITIVE 8'h2A
`define CBU_OP_NEGATIVE 8'h2B
`define CBU_OP_SGE 8'h2C
`define CBU_OP_SLT 8'h2D
`define CBU_OP_SGT 8'h2E
`define CBU_OP_SLE 8'h2F
`define CBU_FLAG_C 0
`define CBU_FLAG_V 1
`define CBU_FLAG_Z 2
`define CBU_FLAG_N 3
`define CBU_PC_STEP 16'h0002
`define CBU_DUMMY_ADDR 16'hFFFF
`define CBU_PC_RESET 16'h0000
`define CBU_BUS_CYCLES 3
`endif

// ---- src/cbu_pkg.sv ----
// Types shared by the branch unit
package cbu_pkg;
  typedef enum logic [1:0] {
    CBU_IDLE,
    CBU_FETCH_OP,
    CBU_FETCH_OFS,
    CBU_DUMMY
  } cbu_state_t;
endpackage
